// File: verilog/swna_pkg.sv
package swna_pkg;
  // Register port widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Register indices as seen on reads; a write adds the write offset.
  localparam logic [6:0] REG_STATUS   = 7'h00;
  localparam logic [6:0] REG_MISSED   = 7'h01;
  localparam logic [6:0] REG_NODE_ADDR = 7'h02;
  localparam logic [6:0] REG_CHAIN    = 7'h03;
  localparam logic [6:0] REG_COMMAND  = 7'h04;
  localparam logic [7:0] WRITE_OFFSET = 8'h80;

  // Chain register fields.
  localparam int unsigned CHN_GP_OE   = 0;
  localparam int unsigned CHN_GP_VAL  = 1;
  localparam int unsigned CHN_SW_EN   = 2;
  localparam int unsigned CHN_RING_INC = 3;
  localparam int unsigned CHN_W       = 4;

  // Status register fields.
  localparam int unsigned STS_RING    = 0;
  localparam int unsigned STS_INCR    = 1;
  localparam int unsigned STS_PROG    = 2;
  localparam int unsigned STS_PEND    = 3;
  localparam int unsigned STS_EFF_LSB = 8;

  // Command register field: apply pending address at once.
  localparam int unsigned CMD_APPLY   = 0;

  // Reset values.
  localparam logic [7:0]      NODE_ADDR_RST = 8'h00;
  localparam logic [CHN_W-1:0] CHAIN_RST   = 4'h0;
  localparam logic [DATA_W-1:0] MISSED_RST = 16'h0000;

  // Node address space.
  localparam logic [7:0] ADDR_RESERVED = 8'hff;
  localparam logic [7:0] ADDR_MAX_NODE = 8'hfe;

  // Command FIFO: direction bit and register index per accepted datagram.
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 8;
endpackage

// File: verilog/swna_fifo_if.sv
`timescale 1ns/100ps
interface swna_fifo_if #(parameter int unsigned W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// File: verilog/swna_fifo.sv
`timescale 1ns/100ps
module swna_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  swna_fifo_if.fifo  f
);
  localparam int unsigned PW = $clog2(D);

  logic [W-1:0]  mem_q [D];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign f.in_ready  = (cnt_q != (PW+1)'(D));
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data  = mem_q[rd_q];
  assign push        = f.in_valid && f.in_ready;
  assign pop         = f.out_valid && f.out_ready;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_q] <= f.in_data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// File: verilog/swna_node.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// [R1] Increment input low: node answers address 0 until software programs another.
// [R2] Increment input high: node answers its programmed address plus one, so 1 unprogrammed.
// [R3] Master drives the node's general-purpose pin low after programming it.
// [R4] Addresses 0 to 254 are programmable, so up to 255 nodes share a bus.
// [R5] Chain output drives low to enable next segment's switch, high isolates.
// [R6] Ring mode when ring-select pin high and UART mode selected; else standard.
// [R7] Ring mode: positive wire input only, negative wire output only.
// [R8] Ring mode with address unprogrammed: output wire rests high.
// [R9] Ring mode with nonzero address: input wire data is forwarded to output.
// [R10] Addressed ring forwards requests and replies onward back to the master.
// [R11] Master gives every ring node a distinct nonzero address.
// [R12] Ring mode ignores the increment input unless enabled for shared ring starts.
// [R13] All registers reset to zero.
// [R14] Writes use register index plus 0x80; reads use the plain index.
// [R15] Registers are read-only, write-only, read-write or cleared on read.
// [R16] Only datagrams with good checksum and own address are acted upon.
// [R17] The all-ones address is never taken as a node address.
// [R18] A new node address takes effect only after the current datagram ends; the apply command moves it at once, even while the link is busy.
module swna_node
  import swna_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              uart_mode_i,
  input  wire logic              ring_select_pin_i,
  input  wire logic              address_increment_input_i,
  output logic                   chain_enable_output_o,
  output logic                   chain_gp_o,
  output logic                   chain_gp_oe_o,
  input  wire logic              wire_data_positive_i,
  output logic                   wire_data_positive_o,
  output logic                   wire_data_positive_oe_o,
  input  wire logic              wire_data_negative_i,
  output logic                   wire_data_negative_o,
  output logic                   wire_data_negative_oe_o,
  input  wire logic              tx_bit_i,
  input  wire logic              tx_en_i,
  output logic                   rx_bit_o,
  input  wire logic              link_busy_i,
  input  wire logic              dgram_valid_i,
  output logic                   dgram_ready_o,
  input  wire logic              dgram_crc_ok_i,
  input  wire logic [7:0]        dgram_node_i,
  input  wire logic [7:0]        dgram_reg_i,
  output logic                   cmd_valid_o,
  input  wire logic              cmd_ready_i,
  output logic                   cmd_write_o,
  output logic      [6:0]        cmd_reg_o
);
  // Match value for a node address plus the increment input.
  function automatic logic [7:0] eff_addr(input logic [7:0] base, input logic inc);
    eff_addr = base + {7'h00, inc};
  endfunction

  logic [7:0]        node_addr_q;
  logic [7:0]        pend_addr_q;
  logic              pend_q;
  logic [CHN_W-1:0]  chain_q;
  logic [DATA_W-1:0] missed_q;
  logic [DATA_W-1:0] rdata_q;
  logic              ring_mode;
  logic              inc_used;
  logic [7:0]        match_addr;
  logic              wr_hit;
  logic [6:0]        wr_idx;
  logic              dgram_take;
  logic              dgram_good;
  logic              miss_evt;
  logic              apply_now;

  swna_fifo_if #(.W(FIFO_W)) cmdq ();

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and address matching.

  assign ring_mode  = ring_select_pin_i && uart_mode_i;                          // [R6]
  assign inc_used   = address_increment_input_i && (!ring_mode || chain_q[CHN_RING_INC]); // [R12]
  assign match_addr = eff_addr(node_addr_q, inc_used);                            // [R1] [R2]

  assign dgram_take = dgram_valid_i && dgram_ready_o;
  assign dgram_good = dgram_crc_ok_i && (dgram_node_i == match_addr)
                      && (dgram_node_i != ADDR_RESERVED);                         // [R16] [R17]
  assign miss_evt   = dgram_take && !dgram_good;

  // Refused datagrams are consumed at once; only good ones wait for FIFO room.
  assign dgram_ready_o  = cmdq.in_ready || !dgram_good;
  assign cmdq.in_valid  = dgram_valid_i && dgram_good;                            // [R16]
  assign cmdq.in_data   = dgram_reg_i;
  assign cmdq.out_ready = cmd_ready_i;
  assign cmd_valid_o    = cmdq.out_valid;
  assign cmd_write_o    = cmdq.out_data[7];                                       // [R14]
  assign cmd_reg_o      = cmdq.out_data[6:0];

  swna_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .f      (cmdq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes. Only addresses with the write offset set are writes.

  assign wr_hit = reg_wr_i && reg_addr_i[7];                                      // [R14]
  assign wr_idx = reg_addr_i[6:0];
  assign apply_now = wr_hit && (wr_idx == REG_COMMAND) && reg_wdata_i[CMD_APPLY];

  // A write lands in a holding register so that the match value cannot move
  // under a datagram that is still being received or answered, except when the apply command moves it.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      node_addr_q <= NODE_ADDR_RST;                                               // [R13]
      pend_addr_q <= NODE_ADDR_RST;
      pend_q      <= 1'b0;
    end else begin
      if (wr_hit && (wr_idx == REG_NODE_ADDR) && (reg_wdata_i[7:0] <= ADDR_MAX_NODE)) begin // [R4] [R17]
        pend_addr_q <= reg_wdata_i[7:0];
        pend_q      <= 1'b1;
      end else if (pend_q && (!link_busy_i || apply_now)) begin                    // [R18]
        node_addr_q <= pend_addr_q;
        pend_q      <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chain_q <= CHAIN_RST;                                                       // [R13]
    end else if (wr_hit && (wr_idx == REG_CHAIN)) begin
      chain_q <= reg_wdata_i[CHN_W-1:0];
    end
  end

  // Clear on read; a refused datagram in the same cycle still counts.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      missed_q <= MISSED_RST;
    end else if (miss_evt) begin
      missed_q <= (reg_rd_i && !reg_addr_i[7] && (reg_addr_i[6:0] == REG_MISSED)) ? 16'h0001
                  : ((missed_q == 16'hffff) ? missed_q : missed_q + 16'h0001);
    end else if (reg_rd_i && !reg_addr_i[7] && (reg_addr_i[6:0] == REG_MISSED)) begin // [R15]
      missed_q <= MISSED_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads: data stand in the cycle after the strobe and only there.

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i && !reg_addr_i[7]) begin
      unique case (reg_addr_i[6:0])                                               // [R15]
        REG_STATUS:   rdata_q <= {match_addr, 4'h0, pend_q, (node_addr_q != 8'h00),
                                  address_increment_input_i, ring_mode};
        REG_MISSED:   rdata_q <= missed_q;
        REG_NODE_ADDR: rdata_q <= {8'h00, node_addr_q};
        REG_CHAIN:    rdata_q <= {{(DATA_W-CHN_W){1'b0}}, chain_q};
        default:      rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Chain outputs and wire pins.

  assign chain_enable_output_o = !chain_q[CHN_SW_EN];                             // [R5]
  assign chain_gp_o            = chain_q[CHN_GP_VAL];
  assign chain_gp_oe_o         = chain_q[CHN_GP_OE];

  // Ring: own reply has priority on the output; otherwise forward once
  // addressed, else idle high so downstream nodes see a quiet line.
  always_comb begin
    if (ring_mode) begin
      wire_data_positive_o    = 1'b1;
      wire_data_positive_oe_o = 1'b0;                                             // [R7]
      wire_data_negative_oe_o = 1'b1;
      if (tx_en_i) begin
        wire_data_negative_o = tx_bit_i;                                          // [R10]
      end else if (node_addr_q != 8'h00) begin
        wire_data_negative_o = wire_data_positive_i;                              // [R9] [R10]
      end else begin
        wire_data_negative_o = 1'b1;                                              // [R8]
      end
      rx_bit_o = wire_data_positive_i;
    end else begin
      wire_data_positive_o    = tx_bit_i;
      wire_data_positive_oe_o = tx_en_i;
      wire_data_negative_o    = !tx_bit_i;
      wire_data_negative_oe_o = tx_en_i;
      rx_bit_o = wire_data_positive_i && !wire_data_negative_i ? 1'b1
               : (!wire_data_positive_i && wire_data_negative_i ? 1'b0 : wire_data_positive_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_good_dgram;
    dgram_valid_i && dgram_crc_ok_i && (dgram_node_i == match_addr)
    && (dgram_node_i != ADDR_RESERVED) && cmdq.in_ready;
  endsequence

  sequence s_rc_read;
    reg_rd_i && !reg_addr_i[7] && (reg_addr_i[6:0] == REG_MISSED) && !miss_evt;
  endsequence

  sequence s_busy_write;
    wr_hit && (wr_idx == REG_NODE_ADDR) && link_busy_i;
  endsequence

  chk_idle_high: assert property (ring_mode && !tx_en_i && (node_addr_q == 8'h00)
    |-> wire_data_negative_o && wire_data_negative_oe_o) // [R8]
    else $error("ring output not idle high while unaddressed");

  chk_ring_fwd: assert property (ring_mode && !tx_en_i && (node_addr_q != 8'h00)
    |-> wire_data_negative_o == wire_data_positive_i) // [R9]
    else $error("ring output does not forward input");

  chk_ring_dirs: assert property (ring_mode |-> !wire_data_positive_oe_o && wire_data_negative_oe_o) // [R7]
    else $error("ring pin directions wrong");

  chk_addr_zero: assert property (!address_increment_input_i && node_addr_q == 8'h00
    && dgram_valid_i && dgram_crc_ok_i && dgram_node_i == 8'h00 && cmdq.in_ready |-> cmdq.in_valid) // [R1]
    else $error("unprogrammed node ignored address 0");

  chk_addr_one: assert property (!ring_mode && address_increment_input_i && node_addr_q == 8'h00
    |-> match_addr == 8'h01) // [R2]
    else $error("incremented node does not answer address 1");

  chk_good_take: assert property (s_good_dgram |=> $past(cmdq.in_valid) && cmd_valid_o) // [R16]
    else $error("good datagram not queued");

  chk_bad_drop: assert property (dgram_valid_i && !dgram_crc_ok_i |-> !cmdq.in_valid ##1 missed_q != 16'h0000) // [R16]
    else $error("bad datagram accepted or not counted");

  chk_no_ff: assert property (node_addr_q != ADDR_RESERVED && pend_addr_q != ADDR_RESERVED) // [R17]
    else $error("reserved address taken");

  chk_chain_low: assert property (chain_q[CHN_SW_EN] |-> !chain_enable_output_o) // [R5]
    else $error("chain output not low when switch enabled");

  chk_hold_busy: assert property (s_busy_write ##1 link_busy_i |-> $stable(node_addr_q)) // [R18]
    else $error("address changed during datagram");

  chk_rc_clear: assert property (s_rc_read |=> missed_q == 16'h0000 && reg_rdata_o == $past(missed_q)) // [R15]
    else $error("clear on read failed");

  chk_wr_offset: assert property (reg_wr_i && !reg_addr_i[7] |=> $stable(chain_q) && !pend_q || $past(pend_q)) // [R14]
    else $error("write without offset changed registers");

  // A held address moves over as soon as the link is quiet and no newer write replaces it.
  sequence s_idle_apply;
    pend_q && !link_busy_i && !(wr_hit && (wr_idx == REG_NODE_ADDR));
  endsequence

  chk_pend_apply: assert property (s_idle_apply |=> !pend_q && node_addr_q == $past(pend_addr_q)) // [R18]
    else $error("pending address not applied while idle");

  chk_cmd_apply: assert property (pend_q && apply_now |=> !pend_q) // [R18]
    else $error("apply command ignored");

  chk_rd_wside: assert property (reg_rd_i && reg_addr_i[7] |=> reg_rdata_o == 16'h0000) // [R14]
    else $error("read at write address returned data");

  chk_rd_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000) // [R15]
    else $error("read data outside the answer cycle");

  chk_ff_refused: assert property (wr_hit && (wr_idx == REG_NODE_ADDR) && (reg_wdata_i[7:0] > ADDR_MAX_NODE)
    |=> $stable(pend_addr_q)) // [R17]
    else $error("out of range node address accepted");

  chk_full_refuse: assert property (dgram_valid_i && dgram_good && !cmdq.in_ready |-> !dgram_ready_o) // [R16]
    else $error("good datagram taken while queue full");

  chk_miss_count: assert property (miss_evt && !reg_rd_i && (missed_q != 16'hffff)
    |=> missed_q == $past(missed_q) + 16'h0001) // [R16]
    else $error("refused datagram not counted");

  chk_std_drive: assert property (!ring_mode |-> (wire_data_negative_oe_o == tx_en_i)
    && (wire_data_negative_o != wire_data_positive_o)) // [R6]
    else $error("standard mode wires not driven as a pair");

  chk_rx_ring: assert property (ring_mode |-> rx_bit_o == wire_data_positive_i) // [R7]
    else $error("ring receive not taken from input wire");

endmodule

// File: testbench/swna_ring_source.sv
`timescale 1ns/100ps
module swna_ring_source (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic frame_i,
  output logic      line_o
);
  logic [7:0] pat_q;

  // The line idles high between frames, and the pattern inside a frame keeps moving so stale data shows up.
  always_ff @(posedge mclk_i) begin
    if (rst_i || !frame_i) begin
      pat_q <= 8'hb4;
    end else begin
      pat_q <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[0]};
    end
  end
  assign line_o = frame_i ? pat_q[0] : 1'b1;
endmodule

// File: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import swna_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        umode = 1'b1;
  logic        ring = 1'b0;
  logic        incr = 1'b0;
  logic        frame = 1'b0;
  logic        tx_bit = 1'b1;
  logic        tx_en = 1'b0;
  logic        busy = 1'b0;
  logic        dv = 1'b0;
  logic        crc = 1'b1;
  logic [7:0]  dnode = 8'h00;
  logic [7:0]  dreg = 8'h00;
  logic        cready = 1'b0;
  logic        chain_en, gp, gp_oe, line, pos_o, pos_oe, neg_o, neg_oe, rx, dready, cvalid, cwrite, took;
  logic [6:0]  creg;
  logic [15:0] v;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  // Wire levels: whoever enables its driver wins, otherwise the master's line.
  wire pos_w = pos_oe ? pos_o : line;
  wire neg_w = neg_oe ? neg_o : ~line;

  swna_node i_swna_node (.mclk_i(mclk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .uart_mode_i(umode), .ring_select_pin_i(ring),
    .address_increment_input_i(incr), .chain_enable_output_o(chain_en), .chain_gp_o(gp), .chain_gp_oe_o(gp_oe),
    .wire_data_positive_i(pos_w), .wire_data_positive_o(pos_o), .wire_data_positive_oe_o(pos_oe),
    .wire_data_negative_i(neg_w), .wire_data_negative_o(neg_o), .wire_data_negative_oe_o(neg_oe),
    .tx_bit_i(tx_bit), .tx_en_i(tx_en), .rx_bit_o(rx), .link_busy_i(busy), .dgram_valid_i(dv),
    .dgram_ready_o(dready), .dgram_crc_ok_i(crc), .dgram_node_i(dnode), .dgram_reg_i(dreg),
    .cmd_valid_o(cvalid), .cmd_ready_i(cready), .cmd_write_o(cwrite), .cmd_reg_o(creg));
  swna_ring_source i_swna_ring_source (.mclk_i(mclk), .rst_i(rst), .frame_i(frame), .line_o(line));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 mclk = ~mclk;
  end
  initial begin
    forever begin
      @(posedge mclk);
      cycles++;
      if (cycles == 20000) begin
        mismatches++;
        complete_run();
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] wa(input logic [6:0] i);
    return WRITE_OFFSET + {1'b0, i};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] q);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic dg(input logic [7:0] n, input logic ok, input logic [7:0] r);
    @(posedge mclk);
    dv <= 1'b1;
    dnode <= n;
    crc <= ok;
    dreg <= r;
    #1 took = dready;
    while (!dready) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    dv <= 1'b0;
  endtask
  task automatic pop(input logic w, input logic [6:0] r);
    #1 chk("cmd_valid", 16'h0001, {15'h0, cvalid});
    chk("cmd_write", {15'h0, w}, {15'h0, cwrite});
    chk("cmd_reg", {9'h0, r}, {9'h0, creg});
    @(posedge mclk);
    cready <= 1'b1;
    @(posedge mclk);
    cready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_access();
    for (int i = 0; i < 4; i++) begin
      rd_reg(i[7:0], v);
      chk("reset value", 16'h0000, v);
    end
    chk("chain_en", 16'h0001, {15'h0, chain_en});
    wr_reg(wa(REG_NODE_ADDR), 16'h0005);
    wr_reg({1'b0, REG_NODE_ADDR}, 16'h0009);
    rd_reg(wa(REG_NODE_ADDR), v);
    chk("write-side read", 16'h0000, v);
    rd_reg({1'b0, REG_NODE_ADDR}, v);
    chk("node address", 16'h0005, v);
    wr_reg(wa(REG_NODE_ADDR), 16'h00ff);
    rd_reg({1'b0, REG_NODE_ADDR}, v);
    chk("reserved addr", 16'h0005, v);
    wr_reg(wa(REG_NODE_ADDR), 16'h00fe);
    rd_reg({1'b0, REG_NODE_ADDR}, v);
    chk("top addr", 16'h00fe, v);
    rd_reg({1'b0, REG_COMMAND}, v);
    chk("write-only", 16'h0000, v);
    rd_reg(8'h10, v);
    chk("unmapped", 16'h0000, v);
    wr_reg(wa(REG_NODE_ADDR), 16'h0000);
  endtask
  task automatic t_match();
    dg(8'h00, 1'b1, 8'h85);
    pop(1'b1, 7'h05);
    dg(8'h01, 1'b1, 8'h01);
    dg(8'h00, 1'b0, 8'h01);
    dg(8'hff, 1'b1, 8'h01);
    incr <= 1'b1;
    dg(8'h00, 1'b1, 8'h01);
    #1 chk("ignored", 16'h0000, {15'h0, cvalid});
    dg(8'h01, 1'b1, 8'h03);
    pop(1'b0, 7'h03);
    rd_reg(8'h00, v);
    chk("incr match", 16'h0102, v & 16'hff02);
    rd_reg({1'b0, REG_MISSED}, v);
    chk("missed", 16'h0004, v);
    rd_reg({1'b0, REG_MISSED}, v);
    chk("missed cleared", 16'h0000, v);
    incr <= 1'b0;
  endtask
  task automatic t_pending();
    busy <= 1'b1;
    wr_reg(wa(REG_NODE_ADDR), 16'h0010);
    rd_reg(8'h00, v);
    chk("pending", 16'h0008, v & 16'hff08);
    dg(8'h00, 1'b1, 8'h01);
    pop(1'b0, 7'h01);
    busy <= 1'b0;
    repeat (2) @(posedge mclk);
    dg(8'h10, 1'b1, 8'h82);
    pop(1'b1, 7'h02);
    busy <= 1'b1;
    wr_reg(wa(REG_NODE_ADDR), 16'h0003);
    wr_reg(wa(REG_COMMAND), 16'h0001);
    rd_reg(8'h00, v);
    chk("applied", 16'h0300, v & 16'hff08);
    busy <= 1'b0;
  endtask
  task automatic t_chain();
    wr_reg(wa(REG_CHAIN), 16'h0001);
    #1 chk("gp drives 0", 16'h0002, {14'h0, gp_oe, gp});
    wr_reg(wa(REG_CHAIN), 16'h0004);
    #1 chk("switch on", 16'h0000, {15'h0, chain_en});
    rd_reg({1'b0, REG_CHAIN}, v);
    chk("chain", 16'h0004, v);
    wr_reg(wa(REG_CHAIN), 16'h0000);
    tx_en <= 1'b1;
    tx_bit <= 1'b1;
    @(posedge mclk);
    #1 chk("std drive", 16'h001d, {11'h0, pos_oe, pos_o, neg_oe, neg_o, rx});
    tx_en <= 1'b0;
  endtask
  task automatic t_ring();
    ring <= 1'b1;
    wr_reg(wa(REG_NODE_ADDR), 16'h0000);
    frame <= 1'b1;
    repeat (4) begin
      @(posedge mclk);
      #1 chk("idle out", 16'h0006, {13'h0, neg_oe, neg_o, pos_oe});
    end
    rd_reg(8'h00, v);
    chk("ring mode", 16'h0001, v & 16'h0001);
    wr_reg(wa(REG_NODE_ADDR), 16'h0003);
    repeat (8) begin
      @(posedge mclk);
      #1 chk("forward", {15'h0, pos_w}, {15'h0, neg_o});
      chk("ring rx", {15'h0, pos_w}, {15'h0, rx});
    end
    frame <= 1'b0;
    incr <= 1'b1;
    tx_en <= 1'b1;
    tx_bit <= 1'b0;
    rd_reg(8'h00, v);
    chk("ring incr", 16'h0301, v & 16'hff01);
    chk("own reply", 16'h0000, {15'h0, neg_o});
    tx_en <= 1'b0;
    dg(8'h03, 1'b1, 8'h84);
    pop(1'b1, 7'h04);
    wr_reg(wa(REG_CHAIN), 16'h0008);
    rd_reg(8'h00, v);
    chk("shared start", 16'h0401, v & 16'hff01);
    wr_reg(wa(REG_CHAIN), 16'h0000);
    umode <= 1'b0;
    rd_reg(8'h00, v);
    chk("no uart", 16'h0000, v & 16'h0001);
    umode <= 1'b1;
    ring <= 1'b0;
    incr <= 1'b0;
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 8; i++) begin
      dg(8'h03, 1'b1, {1'b0, i[6:0]});
      chk("fifo take", 16'h0001, {15'h0, took});
    end
    // The ninth datagram is held until one pop makes room for it.
    fork
      dg(8'h03, 1'b1, 8'h08);
      begin
        repeat (2) @(posedge mclk);
        pop(1'b0, 7'h00);
      end
    join
    chk("fifo full", 16'h0000, {15'h0, took});
    for (int i = 1; i < 9; i++) begin
      pop(1'b0, i[6:0]);
    end
    #1 chk("fifo empty", 16'h0000, {15'h0, cvalid});
  endtask

  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_access();
    t_match();
    t_pending();
    t_chain();
    t_ring();
    t_fifo();
    complete_run();
  end
endmodule
